// ---- hw/psrb_pkg.sv ----
// Package for the port status register bank.
// Assumes a 32-bit APB slave with word-aligned registers.
package psrb_pkg;
   localparam int unsigned NUM_PORTS = 24;
   localparam int unsigned PHY_ENTRIES = 24;
   localparam int unsigned ADDR_WIDTH = 12;
   // Register indices; byte address is four times the index.
   localparam logic [7:0] IDX_INTERRUPT_SOURCE = 8'h01;
   localparam logic [7:0] IDX_PARTITION_STATUS = 8'h03;
   localparam logic [7:0] IDX_PHY_MGMT_ERROR_STATUS = 8'h04;
   localparam logic [7:0] IDX_PORT_ACTIVITY_STATUS = 8'h05;
   localparam logic [7:0] IDX_ERROR_MASK = 8'h1E;
   localparam logic [7:0] IDX_LOOKUP_CLOCK_DELAY = 8'h1F;
   localparam logic [7:0] IDX_PHY_REGISTER_WINDOW = 8'h20;
   localparam logic [7:0] IDX_PHY_REGISTER_LAST = 8'h3F;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
   localparam int unsigned PARTITION_CAUSE_BIT = 2;
   localparam int unsigned INTERRUPT_SOURCE_WIDTH = 8;
   localparam int unsigned MASK_WIDTH = 8;
   localparam int unsigned DELAY_WIDTH = 4;
   localparam int unsigned PHY_DATA_WIDTH = 16;
   localparam int unsigned IRQ_WIDTH = 3;
   localparam int unsigned IRQ_PARTITION = 0;
   localparam int unsigned IRQ_MGMT_ERROR = 1;
   localparam int unsigned IRQ_ACTIVITY = 2;
   localparam logic [7:0] ERROR_MASK_RESET = 8'h00;
   localparam logic [3:0] LOOKUP_DELAY_RESET = 4'h0;
   localparam logic [15:0] PHY_REG_RESET = 16'h0000;
   localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

   typedef struct packed {
      logic [NUM_PORTS-1:0] false_carrier;
      logic [NUM_PORTS-1:0] excess_collision;
      logic [NUM_PORTS-1:0] jabber;
      logic [NUM_PORTS-1:0] mgmt_no_response;
      logic [NUM_PORTS-1:0] activity;
   } psrb_events_type;
endpackage

// ---- hw/psrb_port_status_register_bank.sv ----
// Port status register bank: clear-on-read port status words, configuration and a PHY register window.
// Assumes a synchronous APB master on pclk and port event pulses synchronous to pclk.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
module psrb_port_status_register_bank
#(
   parameter int unsigned NUM_PORTS = psrb_pkg::NUM_PORTS,
   parameter int unsigned PHY_ENTRIES = psrb_pkg::PHY_ENTRIES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [psrb_pkg::ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire psrb_pkg::psrb_events_type port_events,
   output logic [psrb_pkg::NUM_PORTS-1:0] port_partitioned,
   output logic [psrb_pkg::DELAY_WIDTH-1:0] lookup_clock_delay_out,
   output logic [psrb_pkg::MASK_WIDTH-1:0] error_mask_out,
   output logic irq
);
   initial
   begin
      if (NUM_PORTS != psrb_pkg::NUM_PORTS || PHY_ENTRIES < 1 || PHY_ENTRIES > 32)
      begin
         $error("Unsupported port count or PHY entry count.");
      end
   end

   typedef enum logic [1:0] {idle_st, access_st} psrb_bus_state_type;

   psrb_bus_state_type bus_state;
   logic [NUM_PORTS-1:0] partition_status;
   logic [NUM_PORTS-1:0] phy_mgmt_error_status;
   logic [NUM_PORTS-1:0] port_activity_status;
   logic [psrb_pkg::INTERRUPT_SOURCE_WIDTH-1:0] interrupt_source;
   logic [psrb_pkg::MASK_WIDTH-1:0] error_mask;
   logic [psrb_pkg::DELAY_WIDTH-1:0] lookup_clock_delay;
   logic [psrb_pkg::PHY_DATA_WIDTH-1:0] phy_register_window [PHY_ENTRIES];
   logic [psrb_pkg::IRQ_WIDTH-1:0] irq_status;
   logic [psrb_pkg::IRQ_WIDTH-1:0] irq_mask;
   logic [NUM_PORTS-1:0] partition_event;
   logic [7:0] reg_index;
   logic access;
   logic rd_access;
   logic wr_access;
   logic mapped;
   logic [31:0] next_prdata;
   logic [psrb_pkg::IRQ_WIDTH-1:0] irq_events;

   function automatic logic [31:0] widen(input logic [NUM_PORTS-1:0] value);
      widen = 32'(value);
   endfunction

   function automatic logic is_phy_index(input logic [7:0] idx);
      is_phy_index = (idx >= psrb_pkg::IDX_PHY_REGISTER_WINDOW) && (idx <= psrb_pkg::IDX_PHY_REGISTER_LAST)
                     && (32'(idx - psrb_pkg::IDX_PHY_REGISTER_WINDOW) < PHY_ENTRIES);
   endfunction

   // Word index; low two address bits are ignored since every register is one word.
   assign reg_index = paddr[9:2];
   assign access = clk_en && psel && penable && (bus_state == access_st);
   assign rd_access = access && !pwrite;
   assign wr_access = access && pwrite;
   assign partition_event = port_events.false_carrier | port_events.excess_collision | port_events.jabber;
   assign irq_events = {(|port_events.activity), (|port_events.mgmt_no_response), (|partition_event)};

   always_comb
   begin
      mapped = 1'b1;
      next_prdata = psrb_pkg::UNMAPPED_READ;
      case (reg_index)
         psrb_pkg::IDX_INTERRUPT_SOURCE: next_prdata = 32'(interrupt_source);
         psrb_pkg::IDX_PARTITION_STATUS: next_prdata = widen(partition_status);
         psrb_pkg::IDX_PHY_MGMT_ERROR_STATUS: next_prdata = widen(phy_mgmt_error_status);
         psrb_pkg::IDX_PORT_ACTIVITY_STATUS: next_prdata = widen(port_activity_status);
         psrb_pkg::IDX_ERROR_MASK: next_prdata = 32'(error_mask);
         psrb_pkg::IDX_LOOKUP_CLOCK_DELAY: next_prdata = 32'(lookup_clock_delay);
         psrb_pkg::IDX_IRQ_STATUS: next_prdata = 32'(irq_status);
         psrb_pkg::IDX_IRQ_MASK: next_prdata = 32'(irq_mask);
         default:
         begin
            if (is_phy_index(reg_index))
            begin
               next_prdata = 32'(phy_register_window[5'(reg_index - psrb_pkg::IDX_PHY_REGISTER_WINDOW)]);
            end
            else
            begin
               mapped = 1'b0;
            end
         end
      endcase
   end

   // One wait state: setup, then a registered answer, so read data comes from a flip-flop.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bus_state <= idle_st;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else if (clk_en)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         case (bus_state)
            idle_st:
            begin
               if (psel && !penable)
               begin
                  bus_state <= access_st;
               end
            end
            access_st:
            begin
               if (psel && penable && !pready)
               begin
                  pready <= 1'b1;
                  pslverr <= !mapped;
                  prdata <= pwrite ? 32'h00000000 : next_prdata;
               end
               else if (pready)
               begin
                  bus_state <= idle_st;
                  prdata <= 32'h00000000;
               end
            end
            default: bus_state <= idle_st;
         endcase
      end
   end

   // A status word is cleared at the edge that hands its value to the master; events in that cycle stay set.
   logic take;
   assign take = rd_access && !pready;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         partition_status <= '0;
      end
      else if (clk_en)
      begin
         if (take && reg_index == psrb_pkg::IDX_PARTITION_STATUS)
         begin
            partition_status <= partition_event;
         end
         else
         begin
            partition_status <= partition_status | partition_event;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phy_mgmt_error_status <= '0;
      end
      else if (clk_en)
      begin
         if (take && reg_index == psrb_pkg::IDX_PHY_MGMT_ERROR_STATUS)
         begin
            phy_mgmt_error_status <= port_events.mgmt_no_response;
         end
         else
         begin
            phy_mgmt_error_status <= phy_mgmt_error_status | port_events.mgmt_no_response;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_activity_status <= '0;
      end
      else if (clk_en)
      begin
         if (take && reg_index == psrb_pkg::IDX_PORT_ACTIVITY_STATUS)
         begin
            port_activity_status <= port_events.activity;
         end
         else
         begin
            port_activity_status <= port_activity_status | port_events.activity;
         end
      end
   end

   // Only the partition cause is owned here; other source bits stay zero.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         interrupt_source <= '0;
      end
      else if (clk_en)
      begin
         if (take && reg_index == psrb_pkg::IDX_INTERRUPT_SOURCE)
         begin
            interrupt_source <= '0;
            interrupt_source[psrb_pkg::PARTITION_CAUSE_BIT] <= |partition_event;
         end
         else if (|partition_event)
         begin
            interrupt_source[psrb_pkg::PARTITION_CAUSE_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         error_mask <= psrb_pkg::ERROR_MASK_RESET;
         lookup_clock_delay <= psrb_pkg::LOOKUP_DELAY_RESET;
         irq_mask <= '0;
      end
      else if (clk_en && wr_access && !pready && pstrb[0])
      begin
         if (reg_index == psrb_pkg::IDX_ERROR_MASK)
         begin
            error_mask <= pwdata[psrb_pkg::MASK_WIDTH-1:0];
         end
         if (reg_index == psrb_pkg::IDX_LOOKUP_CLOCK_DELAY)
         begin
            lookup_clock_delay <= pwdata[psrb_pkg::DELAY_WIDTH-1:0];
         end
         if (reg_index == psrb_pkg::IDX_IRQ_MASK)
         begin
            irq_mask <= pwdata[psrb_pkg::IRQ_WIDTH-1:0];
         end
      end
   end

   // The window stores values locally; the MDIO engine that mirrors them into the PHYs lives elsewhere.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < PHY_ENTRIES; i++)
         begin
            phy_register_window[i] <= psrb_pkg::PHY_REG_RESET;
         end
      end
      else if (clk_en && wr_access && !pready && is_phy_index(reg_index))
      begin
         if (pstrb[0])
         begin
            phy_register_window[5'(reg_index - psrb_pkg::IDX_PHY_REGISTER_WINDOW)][7:0] <= pwdata[7:0];
         end
         if (pstrb[1])
         begin
            phy_register_window[5'(reg_index - psrb_pkg::IDX_PHY_REGISTER_WINDOW)][15:8] <= pwdata[15:8];
         end
      end
   end

   // Sticky status, write one to clear; a new event in the clear cycle wins.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_status <= '0;
      end
      else if (clk_en)
      begin
         if (wr_access && !pready && pstrb[0] && reg_index == psrb_pkg::IDX_IRQ_STATUS)
         begin
            irq_status <= (irq_status & ~pwdata[psrb_pkg::IRQ_WIDTH-1:0]) | irq_events;
         end
         else
         begin
            irq_status <= irq_status | irq_events;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq <= 1'b0;
         port_partitioned <= '0;
         lookup_clock_delay_out <= psrb_pkg::LOOKUP_DELAY_RESET;
         error_mask_out <= psrb_pkg::ERROR_MASK_RESET;
      end
      else if (clk_en)
      begin
         irq <= |(irq_status & irq_mask);
         port_partitioned <= partition_status;
         lookup_clock_delay_out <= lookup_clock_delay;
         error_mask_out <= error_mask;
      end
   end
endmodule

// ---- verif/psrb_port_status_register_bank_tb.sv ----
// Self-checking testbench for the port status register bank.
// Assumes an APB slave that ends each transfer with pready; the clock enable is dropped only between transfers.
`timescale 1ns/100ps
module psrb_port_status_register_bank_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [psrb_pkg::ADDR_WIDTH-1:0] paddr = '0;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   psrb_pkg::psrb_events_type ev = '0;
   psrb_pkg::psrb_events_type e;
   logic [23:0] part;
   logic [3:0] dly;
   logic [7:0] msk;
   logic irq;
   logic [31:0] rdat;
   logic rerr;
   int failures = 0;
   int total_checks = 0;
   logic [7:0] regs [9] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h1E, 8'h1F, 8'h20, 8'h40, 8'h41};
   psrb_port_status_register_bank dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .port_events(ev), .port_partitioned(part),
      .lookup_clock_delay_out(dly), .error_mask_out(msk), .irq(irq));
   initial
   begin
      forever #5 pclk = ~pclk;
   end
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      if (failures == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Ready, read data and error are taken at the rising edge that ends the access; only then is the request dropped.
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge pclk);
      end
      if (pready !== 1'b1)
      begin
         failures++;
         results();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic er);
      xfer(1'b0, idx, 32'h00000000);
      chk({rerr, rdat}, {er, exp});
   endtask
   task automatic pulse(input psrb_pkg::psrb_events_type v);
      @(posedge pclk);
      ev <= v;
      @(posedge pclk);
      ev <= '0;
      repeat (3) @(posedge pclk);
   endtask
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      foreach (regs[i]) rd(regs[i], 32'h00000000, 1'b0);
      xfer(1'b1, psrb_pkg::IDX_LOOKUP_CLOCK_DELAY, 32'hFFFFFFFF);
      pstrb <= 4'h0;
      xfer(1'b1, psrb_pkg::IDX_LOOKUP_CLOCK_DELAY, 32'h00000003);
      pstrb <= 4'hF;
      rd(psrb_pkg::IDX_LOOKUP_CLOCK_DELAY, 32'h0000000F, 1'b0);
      chk(dly, 4'hF);
      xfer(1'b1, psrb_pkg::IDX_ERROR_MASK, 32'hFFFFFFA5);
      rd(psrb_pkg::IDX_ERROR_MASK, 32'h000000A5, 1'b0);
      chk(msk, 8'hA5);
      xfer(1'b1, 8'h20, 32'hFFFF1234);
      xfer(1'b1, 8'h37, 32'h0000ABCD);
      rd(8'h20, 32'h00001234, 1'b0);
      rd(8'h37, 32'h0000ABCD, 1'b0);
      rd(8'h38, 32'h00000000, 1'b1);
      rd(8'h00, 32'h00000000, 1'b1);
      xfer(1'b1, psrb_pkg::IDX_PARTITION_STATUS, 32'hFFFFFFFF);
      xfer(1'b1, psrb_pkg::IDX_IRQ_MASK, 32'h00000007);
      e = '0;
      e.false_carrier[0] = 1'b1;
      e.excess_collision[12] = 1'b1;
      e.jabber[23] = 1'b1;
      pulse(e);
      chk(part, 24'h801001);
      chk(irq, 1'b1);
      rd(psrb_pkg::IDX_INTERRUPT_SOURCE, 32'h00000004, 1'b0);
      rd(psrb_pkg::IDX_INTERRUPT_SOURCE, 32'h00000000, 1'b0);
      rd(psrb_pkg::IDX_PARTITION_STATUS, 32'h00801001, 1'b0);
      rd(psrb_pkg::IDX_PARTITION_STATUS, 32'h00000000, 1'b0);
      rd(psrb_pkg::IDX_IRQ_STATUS, 32'h00000001, 1'b0);
      xfer(1'b1, psrb_pkg::IDX_IRQ_STATUS, 32'h00000001);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      xfer(1'b1, psrb_pkg::IDX_IRQ_MASK, 32'h00000000);
      e = '0;
      e.mgmt_no_response[5] = 1'b1;
      e.activity[23] = 1'b1;
      pulse(e);
      chk(irq, 1'b0);
      rd(psrb_pkg::IDX_IRQ_STATUS, 32'h00000006, 1'b0);
      rd(psrb_pkg::IDX_PHY_MGMT_ERROR_STATUS, 32'h00000020, 1'b0);
      rd(psrb_pkg::IDX_PHY_MGMT_ERROR_STATUS, 32'h00000000, 1'b0);
      rd(psrb_pkg::IDX_PORT_ACTIVITY_STATUS, 32'h00800000, 1'b0);
      rd(psrb_pkg::IDX_PORT_ACTIVITY_STATUS, 32'h00000000, 1'b0);
      xfer(1'b1, psrb_pkg::IDX_IRQ_MASK, 32'h00000004);
      repeat (3) @(posedge pclk);
      chk(irq, 1'b1);
      xfer(1'b1, psrb_pkg::IDX_IRQ_STATUS, 32'h00000006);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      // The activity pulse meets only the clearing edge, so only the set-wins path can keep it.
      fork
         xfer(1'b0, psrb_pkg::IDX_PORT_ACTIVITY_STATUS, 32'h00000000);
         begin
            repeat (2) @(posedge pclk);
            ev.activity[1] <= 1'b1;
            @(posedge pclk);
            ev <= '0;
         end
      join
      chk({rerr, rdat}, 33'h000000000);
      rd(psrb_pkg::IDX_PORT_ACTIVITY_STATUS, 32'h00000002, 1'b0);
      // With the clock enable low an event must leave no trace.
      e = '0;
      e.activity[7] = 1'b1;
      @(posedge pclk);
      clk_en <= 1'b0;
      ev <= e;
      @(posedge pclk);
      clk_en <= 1'b1;
      ev <= '0;
      rd(psrb_pkg::IDX_PORT_ACTIVITY_STATUS, 32'h00000000, 1'b0);
      results();
   end
endmodule

// ---- verif/psrb_props.sv ----
// Assertion checker for the port status register bank.
// Assumes it is bound to the bank and sees only the bank's ports.
`timescale 1ns/100ps
module psrb_props
#(
   parameter int unsigned NUM_PORTS = psrb_pkg::NUM_PORTS,
   parameter int unsigned PHY_ENTRIES = psrb_pkg::PHY_ENTRIES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [psrb_pkg::ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire psrb_pkg::psrb_events_type port_events,
   input wire logic [psrb_pkg::NUM_PORTS-1:0] port_partitioned,
   input wire logic [psrb_pkg::DELAY_WIDTH-1:0] lookup_clock_delay_out,
   input wire logic [psrb_pkg::MASK_WIDTH-1:0] error_mask_out,
   input wire logic irq
);
   logic [psrb_pkg::NUM_PORTS-1:0] part_ev;
   logic [7:0] idx;
   assign part_ev = port_events.false_carrier | port_events.excess_collision | port_events.jabber;
   assign idx = paddr[9:2];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_one_wait_state: assert property (clk_en && psel && !penable ##1 clk_en && psel && penable |=> pready)
      else $error("Answer missing after one wait state.");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("Answer outside an access phase.");
   a_idle_rdata_zero: assert property (!pready |-> prdata == 32'h00000000)
      else $error("Read data not zero outside an answer.");
   a_unmapped_error: assert property (pready && (idx == 8'h00 || (idx >= psrb_pkg::IDX_PHY_REGISTER_WINDOW + PHY_ENTRIES
      && idx <= psrb_pkg::IDX_PHY_REGISTER_LAST)) |-> pslverr && prdata == 32'h00000000)
      else $error("Unmapped index not refused.");
   a_partition_sets: assert property (part_ev != 0 |=> ##1 (port_partitioned & $past(part_ev, 2)) == $past(part_ev, 2))
      else $error("Partition event did not set its bit.");
   a_partition_cause: assert property ((port_partitioned & ~$past(port_partitioned)) != 0 |-> $past(part_ev, 2) != 0)
      else $error("Partition bit set without an event.");
   a_read_clears: assert property (pready && !pwrite && idx == psrb_pkg::IDX_PARTITION_STATUS && $past(part_ev) == 0
      |=> port_partitioned == 0)
      else $error("Partition word not cleared by a read.");
   a_delay_written: assert property (pready && pwrite && pstrb[0] && idx == psrb_pkg::IDX_LOOKUP_CLOCK_DELAY
      |=> ##1 lookup_clock_delay_out == $past(pwdata[3:0], 2))
      else $error("Lookup clock delay not updated by a write.");
   a_mask_written: assert property (pready && pwrite && pstrb[0] && idx == psrb_pkg::IDX_ERROR_MASK
      |=> ##1 error_mask_out == $past(pwdata[7:0], 2))
      else $error("Error mask not updated by a write.");
endmodule
bind psrb_port_status_register_bank psrb_props #(.NUM_PORTS(NUM_PORTS), .PHY_ENTRIES(PHY_ENTRIES)) u_props (
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .port_events(port_events), .port_partitioned(port_partitioned),
   .lookup_clock_delay_out(lookup_clock_delay_out), .error_mask_out(error_mask_out), .irq(irq));
